// file: verilog/branch_bit_regs.svh
// Constants for the branch and bit-set decoder
`ifndef BRANCH_BIT_REGS_SVH
`define BRANCH_BIT_REGS_SVH
`define OPC_JUMP_PREFIX   5'h1A
`define OPC_JUMP_MSB      15
`define OPC_JUMP_LSB      11
`define OPC_BITOP_MSB     15
`define OPC_BITOP_LSB     12
`define OPC_BIT_SET       4'h8
`define OPC_SKIP_ZERO     4'hB
`define OPC_SKIP_ONE      4'hA
`define FLD_BIT_MSB       11
`define FLD_BIT_LSB       9
`define FLD_ACCESS        8
`define FLD_ADDR_MSB      7
`define FLD_ADDR_LSB      0
`define FLD_OFFS_MSB      10
`define INDEXED_LIMIT     8'h5F
`define ACCESS_SFR_BANK   4'hF
`define PHASE_Q1          2'h0
`define PHASE_Q2          2'h1
`define PHASE_Q3          2'h2
`define PHASE_Q4          2'h3
`define INSTR_NOP         16'h0000
`endif

// file: verilog/branch_bit_pkg.sv
// Types for the branch and bit-set decoder
package branch_bit_pkg;
  typedef enum logic [3:0] {
    OP_NONE = 4'b0001,
    OP_JUMP = 4'b0010,
    OP_BSET = 4'b0100,
    OP_SKIP = 4'b1000
  } op_kind_t;
  typedef enum logic [1:0] {
    CYC_RUN  = 2'b01,
    CYC_FLUSH = 2'b10
  } cyc_state_t;
endpackage : branch_bit_pkg

// file: verilog/data_addr_map.sv
// Data-memory address former for bit-oriented instructions
`timescale 1ns/1ps
`include "branch_bit_regs.svh"
module data_addr_map (
  input  wire logic [7:0]  addr_field,
  input  wire logic        access_flag,
  input  wire logic [3:0]  bank_selector_register,
  input  wire logic        ext_set_en,
  input  wire logic [11:0] index_base,
  output logic      [11:0] data_addr
);
  always_comb begin
    if (access_flag) begin
      data_addr = {bank_selector_register, addr_field};
    end else if (ext_set_en && (addr_field <= `INDEXED_LIMIT)) begin
      data_addr = index_base + {4'h0, addr_field};
    end else if (addr_field[7]) begin
      data_addr = {`ACCESS_SFR_BANK, addr_field};
    end else begin
      data_addr = {4'h0, addr_field};
    end
  end
endmodule : data_addr_map

// file: verilog/branch_bit_decode.sv
// Decode and execute for relative jump, bit set and bit-test skips
// Behaviour
// - Jump: prefix 11010, signed 11-bit offset.
// - Jump target is incremented PC plus 2n.
// - Jump takes two cycles, second is flush.
// - Bit set: opcode, bit, access flag, address.
// - Set only chosen bit; flags untouched.
// - Access flag zero: access bank; else bank.
// - Extended set, flag zero, f<=95: indexed.
// - Skip taken: discard next, execute no-op.
`timescale 1ns/1ps
`include "branch_bit_regs.svh"
module branch_bit_decode #(
  parameter int PC_W = 21
) (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            phase_en,
  input  wire logic [15:0]     instr,
  input  wire logic            instr_valid,
  input  wire logic [PC_W-1:0] pc_in,
  input  wire logic [3:0]      bank_selector_register,
  input  wire logic            ext_set_en,
  input  wire logic [11:0]     index_base,
  input  wire logic [7:0]      mem_rdata,
  output logic      [1:0]      phase_ff,
  output logic      [11:0]     mem_addr_ff,
  output logic                 mem_rd_ff,
  output logic      [7:0]      mem_wdata_ff,
  output logic                 mem_we_ff,
  output logic      [PC_W-1:0] pc_out_ff,
  output logic                 pc_we_ff,
  output logic                 flush_ff,
  output logic                 busy_ff
);
  // Doubled offset needs twelve bits; no more than 32 supported
  localparam int OFFS_W = `FLD_OFFS_MSB + 1;
  if (PC_W < OFFS_W + 1 || PC_W > 32) begin : g_pc_w_check
    $error("PC_W out of range");
  end

  // Upper nibble names the bit-oriented operations
  function automatic logic [3:0] bitop_code(input logic [15:0] w);
    return w[`OPC_BITOP_MSB:`OPC_BITOP_LSB];
  endfunction : bitop_code

  function automatic branch_bit_pkg::op_kind_t classify(input logic [15:0] w);
    branch_bit_pkg::op_kind_t kind;
    case (bitop_code(w))
      `OPC_BIT_SET: begin
        kind = branch_bit_pkg::OP_BSET;
      end
      `OPC_SKIP_ZERO, `OPC_SKIP_ONE: begin
        kind = branch_bit_pkg::OP_SKIP;
      end
      default: begin
        kind = branch_bit_pkg::OP_NONE;
      end
    endcase
    // Jump prefix lies outside the bit-operation codes
    if (w[`OPC_JUMP_MSB:`OPC_JUMP_LSB] == `OPC_JUMP_PREFIX) begin
      kind = branch_bit_pkg::OP_JUMP;
    end
    return kind;
  endfunction : classify

  // Word, kind and PC held for the running instruction
  branch_bit_pkg::cyc_state_t state_ff;
  branch_bit_pkg::op_kind_t   op_ff;
  logic [15:0]                word_ff;
  logic [PC_W-1:0]            pc_ff;
  logic [11:0]                addr_now;
  logic [2:0]                 bit_pos;
  logic                       bit_val;
  logic signed [PC_W-1:0]     offs_ext;
  logic                       skip_hit;
  logic                       nxt_flush;
  logic [7:0]                 set_mask;
  logic [PC_W-1:0]            nxt_pc;

  assign bit_pos  = word_ff[`FLD_BIT_MSB:`FLD_BIT_LSB];
  assign bit_val  = mem_rdata[bit_pos];
  assign offs_ext = PC_W'(signed'(word_ff[`FLD_OFFS_MSB:0]));
  // Target wraps at PC_W bits, as the counter does
  assign nxt_pc   = PC_W'(pc_ff + PC_W'(offs_ext <<< 1));
  // Skip decided at the end of Q4 from the tested bit read back
  assign skip_hit = (bitop_code(word_ff) == `OPC_SKIP_ZERO) ? !bit_val : bit_val;
  // A jump or a taken skip spends the next cycle on a no-op
  assign nxt_flush = (state_ff == branch_bit_pkg::CYC_RUN) &&
                     (op_ff == branch_bit_pkg::OP_JUMP ||
                      (op_ff == branch_bit_pkg::OP_SKIP && skip_hit));

  // One-hot mask of the bit to force high
  for (genvar gi = 0; gi < 8; gi++) begin : g_set_mask
    assign set_mask[gi] = (bit_pos == 3'(gi));
  end

  // Address formed from the incoming word so it stands from Q2
  data_addr_map i_data_addr_map (
    .addr_field             (instr[`FLD_ADDR_MSB:`FLD_ADDR_LSB]),
    .access_flag            (instr[`FLD_ACCESS]),
    .bank_selector_register (bank_selector_register),
    .ext_set_en             (ext_set_en),
    .index_base             (index_base),
    .data_addr              (addr_now)
  );

  // Four-phase counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_ff <= `PHASE_Q1;
    end else if (phase_en) begin
      phase_ff <= phase_ff + 2'h1;
    end
  end

  // Q1 latch of the instruction word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      word_ff <= `INSTR_NOP;
      op_ff   <= branch_bit_pkg::OP_NONE;
    end else if (phase_en && phase_ff == `PHASE_Q1) begin
      if (state_ff == branch_bit_pkg::CYC_FLUSH || !instr_valid) begin
        word_ff <= `INSTR_NOP;
        op_ff   <= branch_bit_pkg::OP_NONE;
      end else begin
        word_ff <= instr;
        op_ff   <= classify(instr);
      end
    end
  end

  // Incremented PC captured with the word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_ff <= '0;
    end else if (phase_en && phase_ff == `PHASE_Q1) begin
      pc_ff <= pc_in;
    end
  end

  // Cycle state: run or flush
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= branch_bit_pkg::CYC_RUN;
    end else if (phase_en && phase_ff == `PHASE_Q4) begin
      case (state_ff)
        branch_bit_pkg::CYC_RUN: begin
          if (nxt_flush) begin
            state_ff <= branch_bit_pkg::CYC_FLUSH;
          end
        end
        branch_bit_pkg::CYC_FLUSH: begin
          state_ff <= branch_bit_pkg::CYC_RUN;
        end
        default: begin
          state_ff <= branch_bit_pkg::CYC_RUN;
        end
      endcase
    end
  end

  // Flush and busy flags for the refill cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flush_ff <= 1'b0;
      busy_ff  <= 1'b0;
    end else if (phase_en && phase_ff == `PHASE_Q4) begin
      flush_ff <= nxt_flush;
      busy_ff  <= nxt_flush;
    end
  end

  // Read strobe and address, both from the incoming word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_addr_ff <= '0;
      mem_rd_ff   <= 1'b0;
    end else if (phase_en) begin
      mem_rd_ff <= 1'b0;
      if (phase_ff == `PHASE_Q1) begin
        mem_addr_ff <= addr_now;
        if (state_ff == branch_bit_pkg::CYC_RUN && instr_valid &&
            classify(instr) inside
            {branch_bit_pkg::OP_BSET, branch_bit_pkg::OP_SKIP}) begin
          mem_rd_ff <= 1'b1;
        end
      end
    end
  end

  // Write back in Q4, only the chosen bit forced high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_we_ff    <= 1'b0;
      mem_wdata_ff <= '0;
    end else begin
      mem_we_ff <= 1'b0;
      if (phase_en && phase_ff == `PHASE_Q3 && op_ff == branch_bit_pkg::OP_BSET) begin
        mem_wdata_ff <= mem_rdata | set_mask;
        mem_we_ff    <= 1'b1;
      end
    end
  end

  // Program counter write in Q4 of the jump
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc_out_ff <= '0;
      pc_we_ff  <= 1'b0;
    end else begin
      pc_we_ff <= 1'b0;
      if (phase_en && phase_ff == `PHASE_Q3 && op_ff == branch_bit_pkg::OP_JUMP &&
          state_ff == branch_bit_pkg::CYC_RUN) begin
        pc_out_ff <= nxt_pc;
        pc_we_ff  <= 1'b1;
      end
    end
  end
endmodule : branch_bit_decode

// file: sim/branch_bit_decode_sva.sv
// Assertion checker for the branch and bit-set decoder
`timescale 1ns/1ps
module branch_bit_decode_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       phase_en,
  input wire logic [1:0] phase_ff,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] mem_wdata_ff,
  input wire logic       mem_we_ff,
  input wire logic       pc_we_ff,
  input wire logic       flush_ff,
  input wire logic       busy_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_PHASE: assert property (##1 phase_ff == $past(phase_ff) + $past(phase_en))
    else $error("phase step wrong");
  AST_WE_ONE: assert property (mem_we_ff |=> !mem_we_ff)
    else $error("write strobe too long");
  AST_PCWE_ONE: assert property (pc_we_ff |=> !pc_we_ff)
    else $error("pc write too long");
  AST_FLUSH: assert property (pc_we_ff |-> ##[0:4] flush_ff)
    else $error("no flush after jump");
  AST_BIT: assert property (mem_we_ff |-> (mem_wdata_ff | mem_rdata) == mem_wdata_ff
    && $countones(mem_wdata_ff ^ mem_rdata) <= 1)
    else $error("write data wrong");
  AST_FL_WE: assert property (flush_ff |-> !mem_we_ff && !pc_we_ff)
    else $error("write during flush");
  AST_BUSY: assert property (busy_ff == flush_ff)
    else $error("busy differs from flush");
  AST_RST: assert property (disable iff (1'b0) rst |=> !mem_we_ff && !pc_we_ff && !flush_ff)
    else $error("outputs not cleared");
endmodule : branch_bit_decode_sva

// file: sim/branch_bit_decode_tb_top.sv
// Testbench for the branch and bit-set decoder
`timescale 1ns/1ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, a); end end
module branch_bit_decode_tb_top;
  logic        core_clk, rst, phase_en, instr_valid, ext_set_en, mem_we_ff, mem_rd_ff;
  logic        pc_we_ff, flush_ff, busy_ff;
  logic [1:0]  phase_ff;
  logic [3:0]  bank_selector_register;
  logic [7:0]  mem_rdata, mem_wdata_ff, wd;
  logic [11:0] index_base, mem_addr_ff, ad, ra;
  logic [15:0] instr;
  logic [20:0] pc_in, pc_out_ff, pcv;
  int          errors, comparisons, np, nw, nf, nr;
  branch_bit_decode i_branch_bit_decode (.core_clk, .rst, .phase_en, .instr, .instr_valid,
    .pc_in, .bank_selector_register, .ext_set_en, .index_base, .mem_rdata, .phase_ff,
    .mem_addr_ff, .mem_rd_ff, .mem_wdata_ff, .mem_we_ff, .pc_out_ff, .pc_we_ff, .flush_ff,
    .busy_ff);
  task automatic cyc(input logic [15:0] w);
    np = 0;
    nw = 0;
    nf = 0;
    nr = 0;
    for (int k = 0; k < 8 && phase_ff !== 2'h0; k++) @(negedge core_clk);
    instr = w;
    repeat (4) begin
      @(negedge core_clk);
      if (pc_we_ff === 1'b1) begin np++; pcv = pc_out_ff; end
      if (mem_we_ff === 1'b1) begin nw++; wd = mem_wdata_ff; ad = mem_addr_ff; end
      if (flush_ff === 1'b1) nf++;
      if (mem_rd_ff === 1'b1) begin nr++; ra = mem_addr_ff; end
    end
  endtask : cyc
  task automatic t_jump(input logic [15:0] w, input logic [20:0] pc, exp);
    pc_in = pc;
    cyc(w);
    `CHK("pc writes", 1, np)
    `CHK("jump reads", 0, nr)
    `CHK("target", exp, pcv)
    cyc(16'h8E12);
    `CHK("flush", 1, nf > 0)
    `CHK("flushed write", 0, nw)
    $display("jump test done");
  endtask : t_jump
  task automatic t_set(input logic [15:0] w, input logic x, input logic [7:0] rd, exd,
                       input logic [11:0] exa);
    ext_set_en = x;
    mem_rdata = rd;
    cyc(w);
    `CHK("writes", 1, nw)
    `CHK("reads", 1, nr)
    `CHK("read addr", exa, ra)
    `CHK("wdata", exd, wd)
    `CHK("addr", exa, ad)
    $display("bit set test done");
  endtask : t_set
  task automatic t_skip(input logic [15:0] w, input logic [7:0] rd, input int taken);
    mem_rdata = rd;
    cyc(w);
    cyc(16'h8E12);
    `CHK("skip writes", 1 - taken, nw)
    `CHK("skip flush", taken, nf > 0)
    $display("skip test done");
  endtask : t_skip
  task automatic give_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #5000;
    errors++;
    give_verdict();
  end
  initial begin
    {rst, phase_en, instr_valid, ext_set_en, instr, pc_in, mem_rdata} = '0;
    bank_selector_register = 4'h3;
    index_base = 12'h100;
    errors = 0;
    comparisons = 0;
    rst = 1;
    repeat (16) @(negedge core_clk);
    {rst, phase_en, instr_valid} = 3'h3;
    t_jump(16'hD400, 21'h00_1000, 21'h00_0800);
    t_jump(16'hD3FF, 21'h00_0200, 21'h00_09FE);
    t_set(16'h8F12, 0, 8'h0A, 8'h8A, 12'h312);
    t_set(16'h8080, 0, 8'hFE, 8'hFF, 12'hF80);
    t_set(16'h805F, 1, 8'h00, 8'h01, 12'h15F);
    t_set(16'h8060, 1, 8'h10, 8'h11, 12'h060);
    t_skip(16'hB012, 8'hFE, 1);
    t_skip(16'hA012, 8'hFE, 0);
    t_skip(16'hA012, 8'h01, 1);
    give_verdict();
  end
endmodule : branch_bit_decode_tb_top
bind branch_bit_decode branch_bit_decode_sva i_branch_bit_decode_sva (.core_clk, .rst,
  .phase_en, .phase_ff, .mem_rdata, .mem_wdata_ff, .mem_we_ff, .pc_we_ff, .flush_ff, .busy_ff);
